// >>> rtl/awsc_core.sv
// Streaming write command interpreter with completion time limit
module awsc_core (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic enable_in,
   input wire awsc_pkg::awsc_taskfile_t taskfile_in,
   input wire logic command_write_in,
   input wire logic hob_in,
   input wire logic [15:0] time_unit_us_in,
   input wire logic [15:0] min_limit_us_in,
   input wire logic cfg_write_in,
   input wire logic [2:0] cfg_stream_in,
   input wire logic [7:0] cfg_default_limit_in,
   input wire logic sector_done_in,
   input wire awsc_pkg::awsc_sector_err_t sector_err_in,
   input wire logic flush_done_in,
   output logic sector_request_out,
   output logic [47:0] sector_lba_out,
   output logic urgent_out,
   output logic [2:0] stream_out,
   output logic flush_request_out,
   output logic complete_out,
   output logic [7:0] command_status_flags_out,
   output logic [7:0] command_error_flags_out,
   output logic [7:0] lba_low_out,
   output logic [7:0] lba_mid_out,
   output logic [7:0] lba_high_out
);
   typedef enum logic [1:0] {S_IDLE, S_XFER, S_FLUSH, S_DONE} awsc_state_t;

   // Stream recovery state and settings, one entry per stream
   awsc_pkg::awsc_stream_cfg_t stream_cfg [awsc_pkg::STREAMS];
   logic [47:0] stream_err_lba [awsc_pkg::STREAMS];
   logic stream_err_valid [awsc_pkg::STREAMS];

   awsc_state_t state, next_state;
   logic [16:0] remaining, next_remaining;
   logic [47:0] cur_lba, next_cur_lba;
   logic [2:0] stream, next_stream;
   logic continuous, next_continuous;
   logic flush, next_flush;
   logic urgent, next_urgent;
   logic dma_cmd, next_dma_cmd;
   logic limit_on, next_limit_on;
   logic [31:0] limit_us, next_limit_us;
   logic [31:0] elapsed_us, next_elapsed_us;
   logic [6:0] us_tick, next_us_tick;
   logic err_seen, next_err_seen;
   logic [47:0] first_err_lba, next_first_err_lba;
   logic [7:0] status, next_status;
   logic [7:0] error, next_error;
   logic complete, next_complete;

   // Picks low or high byte of an LBA field by HOB
   function automatic logic [7:0] hob_byte(input logic [47:0] lba, input int lo, input logic hob);
      hob_byte = hob ? lba[lo+24 +: 8] : lba[lo +: 8];
   endfunction : hob_byte

   // Raw limit selection: supplied value or stream default
   logic [7:0] raw_limit;
   logic [31:0] product_us;
   logic is_stream_cmd;
   logic any_err;
   logic timeout;
   always_comb begin
      raw_limit = (taskfile_in.feature_prev != 8'h00) ? taskfile_in.feature_prev :
         (stream_cfg[taskfile_in.feature_cur[2:0]].valid ?
          stream_cfg[taskfile_in.feature_cur[2:0]].default_limit : 8'h00);
      product_us = 32'(raw_limit) * 32'(time_unit_us_in);
      is_stream_cmd = (taskfile_in.opcode == awsc_pkg::OP_STREAM_PIO) ||
         (taskfile_in.opcode == awsc_pkg::OP_STREAM_DMA);
      any_err = sector_err_in.crc_err | sector_err_in.idnf_err | sector_err_in.abrt_err;
      timeout = limit_on && (elapsed_us >= limit_us);
   end

   // Command sequencing next-state logic
   always_comb begin
      next_state = state;
      next_remaining = remaining;
      next_cur_lba = cur_lba;
      next_stream = stream;
      next_continuous = continuous;
      next_flush = flush;
      next_urgent = urgent;
      next_dma_cmd = dma_cmd;
      next_limit_on = limit_on;
      next_limit_us = limit_us;
      next_elapsed_us = elapsed_us;
      next_us_tick = us_tick;
      next_err_seen = err_seen;
      next_first_err_lba = first_err_lba;
      next_status = status;
      next_error = error;
      next_complete = 1'b0;
      // Count elapsed microseconds while a command runs
      if (state == S_XFER || state == S_FLUSH) begin
         if (us_tick == awsc_pkg::CYCLES_PER_US_M1) begin
            next_us_tick = 7'h00;
            next_elapsed_us = elapsed_us + 32'h1;
         end else begin
            next_us_tick = us_tick + 7'h01;
         end
      end
      unique case (state)
         S_IDLE, S_DONE: begin
            if (command_write_in && is_stream_cmd) begin
               next_state = S_XFER;
               next_status = 8'h80;                                                      // BSY while busy
               next_error = awsc_pkg::ERROR_RESET;
               next_remaining = (taskfile_in.count == 16'h0000) ?
                  awsc_pkg::MAX_SECTORS : {1'b0, taskfile_in.count};
               next_stream = taskfile_in.feature_cur[2:0];
               next_cur_lba = (taskfile_in.feature_cur[awsc_pkg::FEAT_HANDLE_ERR] &&
                  stream_err_valid[taskfile_in.feature_cur[2:0]]) ?
                  stream_err_lba[taskfile_in.feature_cur[2:0]] : taskfile_in.lba;
               next_continuous = taskfile_in.feature_cur[awsc_pkg::FEAT_CONTINUOUS];
               next_flush = taskfile_in.feature_cur[awsc_pkg::FEAT_FLUSH];
               next_urgent = taskfile_in.feature_cur[awsc_pkg::FEAT_URGENT];
               next_dma_cmd = (taskfile_in.opcode == awsc_pkg::OP_STREAM_DMA);
               next_limit_on = (raw_limit != 8'h00);
               next_limit_us = (product_us < 32'(min_limit_us_in)) ?
                  32'(min_limit_us_in) : product_us;
               next_elapsed_us = 32'h0;
               next_us_tick = 7'h00;
               next_err_seen = 1'b0;
               next_first_err_lba = 48'h0;
            end
         end
         S_XFER: begin
            if (timeout) begin
               next_error[awsc_pkg::ERRB_CCTO] = 1'b1;
               next_state = S_DONE;
               next_status = continuous ? 8'h60 : 8'h41;
               next_complete = 1'b1;
            end else if (sector_done_in) begin
               next_remaining = remaining - 17'h1;
               next_cur_lba = cur_lba + 48'h1;
               if (any_err) begin
                  next_error[awsc_pkg::ERRB_CRC] = error[awsc_pkg::ERRB_CRC] |
                     (sector_err_in.crc_err & dma_cmd);
                  next_error[awsc_pkg::ERRB_IDNF] = error[awsc_pkg::ERRB_IDNF] | sector_err_in.idnf_err;
                  next_error[awsc_pkg::ERRB_ABRT] = error[awsc_pkg::ERRB_ABRT] | sector_err_in.abrt_err;
                  if (!err_seen) begin
                     next_err_seen = 1'b1;
                     next_first_err_lba = cur_lba;
                  end
               end
               if (any_err && !continuous) begin
                  next_state = S_DONE;                                                    // Abort on error
                  next_status = 8'h41;
                  next_complete = 1'b1;
               end else if (remaining == 17'h1) begin
                  next_state = flush ? S_FLUSH : S_DONE;
                  if (!flush) begin
                     next_status = (err_seen || any_err) ? 8'h60 : awsc_pkg::STATUS_RESET;
                     next_complete = 1'b1;
                  end
               end
            end
         end
         S_FLUSH: begin
            if (timeout) begin
               next_error[awsc_pkg::ERRB_CCTO] = 1'b1;
               next_state = S_DONE;
               next_status = continuous ? 8'h60 : 8'h41;
               next_complete = 1'b1;
            end else if (flush_done_in) begin
               next_state = S_DONE;
               next_status = err_seen ? 8'h60 : awsc_pkg::STATUS_RESET;
               next_complete = 1'b1;
            end
         end
      endcase
   end

   // Command state registers
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         state <= S_IDLE;
         remaining <= 17'h0;
         cur_lba <= 48'h0;
         stream <= 3'h0;
         continuous <= 1'b0;
         flush <= 1'b0;
         urgent <= 1'b0;
         dma_cmd <= 1'b0;
         limit_on <= 1'b0;
         limit_us <= 32'h0;
         elapsed_us <= 32'h0;
         us_tick <= 7'h00;
         err_seen <= 1'b0;
         first_err_lba <= 48'h0;
         status <= awsc_pkg::STATUS_RESET;
         error <= awsc_pkg::ERROR_RESET;
         complete <= 1'b0;
      end else if (enable_in) begin
         state <= next_state;
         remaining <= next_remaining;
         cur_lba <= next_cur_lba;
         stream <= next_stream;
         continuous <= next_continuous;
         flush <= next_flush;
         urgent <= next_urgent;
         dma_cmd <= next_dma_cmd;
         limit_on <= next_limit_on;
         limit_us <= next_limit_us;
         elapsed_us <= next_elapsed_us;
         us_tick <= next_us_tick;
         err_seen <= next_err_seen;
         first_err_lba <= next_first_err_lba;
         status <= next_status;
         error <= next_error;
         complete <= next_complete;
      end
   end

   // Per-stream settings and last reported error LBA
   generate
      for (genvar s = 0; s < awsc_pkg::STREAMS; s++) begin : g_stream
         awsc_pkg::awsc_stream_cfg_t next_cfg;
         logic [47:0] next_err_lba;
         logic next_err_valid;
         always_comb begin
            next_cfg = stream_cfg[s];
            next_err_lba = stream_err_lba[s];
            next_err_valid = stream_err_valid[s];
            if (cfg_write_in && cfg_stream_in == 3'(s)) begin
               next_cfg.valid = 1'b1;
               next_cfg.default_limit = cfg_default_limit_in;
            end
            if (complete && stream == 3'(s) && err_seen) begin
               next_err_lba = first_err_lba;
               next_err_valid = 1'b1;
            end
         end
         always_ff @(posedge clock_in) begin
            if (rst_in) begin
               stream_cfg[s] <= '0;
               stream_err_lba[s] <= 48'h0;
               stream_err_valid[s] <= 1'b0;
            end else if (enable_in) begin
               stream_cfg[s] <= next_cfg;
               stream_err_lba[s] <= next_err_lba;
               stream_err_valid[s] <= next_err_valid;
            end
         end
      end
   endgenerate

   // Registered outputs
   logic sector_request, next_sector_request;
   logic flush_request, next_flush_request;
   logic [7:0] lba_low, lba_mid, lba_high, next_lba_low, next_lba_mid, next_lba_high;
   always_comb begin
      next_sector_request = (next_state == S_XFER);
      next_flush_request = (next_state == S_FLUSH);
      next_lba_low = hob_byte(first_err_lba, 0, hob_in);
      next_lba_mid = hob_byte(first_err_lba, 8, hob_in);
      next_lba_high = hob_byte(first_err_lba, 16, hob_in);
   end
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         sector_request <= 1'b0;
         flush_request <= 1'b0;
         lba_low <= 8'h00;
         lba_mid <= 8'h00;
         lba_high <= 8'h00;
      end else if (enable_in) begin
         sector_request <= next_sector_request;
         flush_request <= next_flush_request;
         lba_low <= next_lba_low;
         lba_mid <= next_lba_mid;
         lba_high <= next_lba_high;
      end
   end

   assign sector_request_out = sector_request;
   assign sector_lba_out = cur_lba;
   assign urgent_out = urgent;
   assign stream_out = stream;
   assign flush_request_out = flush_request;
   assign complete_out = complete;
   assign command_status_flags_out = status;
   assign command_error_flags_out = error;
   assign lba_low_out = lba_low;
   assign lba_mid_out = lba_mid;
   assign lba_high_out = lba_high;
endmodule : awsc_core

// >>> rtl/awsc_pkg.sv
// Package with constants and types for the streaming write command block
package awsc_pkg;
   // Opcodes
   localparam logic [7:0] OP_STREAM_DMA = 8'h3A;
   localparam logic [7:0] OP_STREAM_PIO = 8'h3B;
   // Feature current bit positions
   localparam int FEAT_URGENT = 7;
   localparam int FEAT_CONTINUOUS = 6;
   localparam int FEAT_FLUSH = 5;
   localparam int FEAT_HANDLE_ERR = 4;
   // Error register bit positions
   localparam int ERRB_CRC = 7;
   localparam int ERRB_IDNF = 4;
   localparam int ERRB_ABRT = 2;
   localparam int ERRB_CCTO = 0;
   // Status register bit positions
   localparam int STB_RDY = 6;
   localparam int STB_SE = 5;
   localparam int STB_ERR = 0;
   // Reset values
   localparam logic [7:0] STATUS_RESET = 8'h40;
   localparam logic [7:0] ERROR_RESET = 8'h00;
   // Timing: 100 MHz clock, cycles per microsecond
   localparam int CLOCK_MHZ = 100;
   localparam int CYCLES_PER_US = CLOCK_MHZ;
   localparam logic [6:0] CYCLES_PER_US_M1 = 7'(CYCLES_PER_US - 1);
   // Default time unit and minimum limit, in microseconds
   localparam logic [31:0] TIME_UNIT_US_DEFAULT = 32'h0000_000A;
   localparam logic [31:0] MIN_LIMIT_US_DEFAULT = 32'h0000_0064;
   // Number of streams
   localparam int STREAMS = 8;
   // Zero sector count means maximum transfer
   localparam logic [16:0] MAX_SECTORS = 17'h10000;

   // Task-file command block written by the host
   typedef struct packed {
      logic [7:0] feature_cur;
      logic [7:0] feature_prev;
      logic [15:0] count;
      logic [47:0] lba;
      logic [7:0] device;
      logic [7:0] opcode;
   } awsc_taskfile_t;

   // Result of a data sector from the media engine
   typedef struct packed {
      logic crc_err;
      logic idnf_err;
      logic abrt_err;
   } awsc_sector_err_t;

   // Stream settings established earlier
   typedef struct packed {
      logic valid;
      logic [7:0] default_limit;
   } awsc_stream_cfg_t;
endpackage : awsc_pkg

// >>> test/awsc_chk.sv
// Checker of the streaming write command interpreter ports
module awsc_chk (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic enable_in,
   input wire awsc_pkg::awsc_taskfile_t taskfile_in,
   input wire logic command_write_in,
   input wire logic flush_done_in,
   input wire logic sector_request_out,
   input wire logic urgent_out,
   input wire logic [2:0] stream_out,
   input wire logic flush_request_out,
   input wire logic complete_out,
   input wire logic [7:0] command_status_flags_out,
   input wire logic [7:0] command_error_flags_out
);
   logic take;
   logic [7:0] feat_q;
   logic [7:0] next_feat_q;
   logic [7:0] op_q;
   logic [7:0] next_op_q;
   // Capture features and opcode of an accepted command
   always_comb begin
      take = enable_in && command_write_in && !command_status_flags_out[7]
         && (taskfile_in.opcode == awsc_pkg::OP_STREAM_DMA || taskfile_in.opcode == awsc_pkg::OP_STREAM_PIO);
      next_feat_q = take ? taskfile_in.feature_cur : feat_q;
      next_op_q = take ? taskfile_in.opcode : op_q;
   end
   // Register captured command fields
   always_ff @(posedge clock_in) begin
      feat_q <= rst_in ? 8'h00 : next_feat_q;
      op_q <= rst_in ? 8'h00 : next_op_q;
   end
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);
   cmd_busy_a: assert property (take |=> command_status_flags_out == 8'h80)
      else $error("status not busy after command");
   end_status_a: assert property (complete_out |-> (command_status_flags_out & 8'h94) == 8'h00)
      else $error("busy, write fault or corrected set at end");
   err_layout_a: assert property (complete_out |-> (command_error_flags_out & 8'h6A) == 8'h00)
      else $error("reserved error bits set");
   cont_noerr_a: assert property (complete_out && feat_q[6] |-> !command_status_flags_out[0])
      else $error("error bit set in continuous mode");
   cont_se_a: assert property (complete_out && feat_q[6] && command_error_flags_out != 8'h00
      |-> command_status_flags_out[5])
      else $error("stream error bit missing");
   pio_nocrc_a: assert property (complete_out && op_q == awsc_pkg::OP_STREAM_PIO |-> !command_error_flags_out[7])
      else $error("crc logged for pio command");
   flush_wait_a: assert property (flush_request_out && !flush_done_in |=> !complete_out)
      else $error("completion before flush finished");
   stream_sel_a: assert property (sector_request_out |-> stream_out == feat_q[2:0])
      else $error("stream id not applied");
   urgent_flag_a: assert property (sector_request_out |-> urgent_out == feat_q[7])
      else $error("urgent flag not applied");
   cover property (complete_out && command_error_flags_out[0]);
   cover property (complete_out && feat_q[5]);
   cover property (complete_out && command_status_flags_out == 8'h60);
endmodule : awsc_chk
bind awsc_core awsc_chk u_chk (.*);

// >>> test/awsc_media_model.sv
// Media engine model answering sector and flush requests
module awsc_media_model (
   input wire logic clock_in,
   input wire logic sector_request_in,
   input wire logic flush_request_in,
   input wire logic [15:0] delay_in,
   input wire logic [15:0] err_idx_in,
   input wire logic [2:0] err_kind_in,
   output logic sector_done_out,
   output awsc_pkg::awsc_sector_err_t sector_err_out,
   output logic flush_done_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] wait_cnt = 16'h0000;
   logic [15:0] idx = 16'h0000;
   initial begin
      sector_done_out = 1'b0;
      sector_err_out = 3'h0;
      flush_done_out = 1'b0;
   end
   // One sector per pulse after a programmable wait, then a flush answer
   always @(negedge clock_in) begin
      sector_done_out <= 1'b0;
      flush_done_out <= 1'b0;
      sector_err_out <= ~sector_err_out; // Not valid outside pulses
      if (!sector_request_in && !flush_request_in) begin
         idx <= 16'h0000;
         wait_cnt <= 16'h0000;
      end else if (sector_done_out || flush_done_out) begin
         wait_cnt <= 16'h0000;
      end else if (wait_cnt >= delay_in) begin
         sector_done_out <= sector_request_in;
         flush_done_out <= flush_request_in && !sector_request_in;
         sector_err_out <= (idx == err_idx_in) ? err_kind_in : 3'h0;
         idx <= idx + 16'h0001;
      end else begin
         wait_cnt <= wait_cnt + 16'h0001;
      end
   end
endmodule : awsc_media_model

// >>> test/test_ata_write_stream_command.sv
// Testbench of the streaming write command interpreter
module test_ata_write_stream_command;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; $display("mismatch at %0t: value", $time); end end
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   logic enable_in = 1'b1;
   awsc_pkg::awsc_taskfile_t taskfile_in = '0;
   logic command_write_in = 1'b0;
   logic hob_in = 1'b0;
   logic [15:0] time_unit_us_in = 16'h0001;
   logic [15:0] min_limit_us_in = 16'h0002;
   logic cfg_write_in = 1'b0;
   logic [2:0] cfg_stream_in = 3'h0;
   logic [7:0] cfg_default_limit_in = 8'h00;
   logic sector_done_in;
   logic flush_done_in;
   awsc_pkg::awsc_sector_err_t sector_err_in;
   logic sector_request_out, urgent_out, flush_request_out, complete_out;
   logic [47:0] sector_lba_out;
   logic [2:0] stream_out;
   logic [7:0] command_status_flags_out, command_error_flags_out, lba_low_out, lba_mid_out, lba_high_out;
   logic [15:0] m_dly = 16'h0000;
   logic [15:0] m_eidx = 16'hFFFF;
   logic [2:0] m_kind = 3'h0;
   int num_errors = 0;
   int checks = 0;
   int seed = 11674;
   int cycles = 0;
   int cfg_def [8] = '{default: 0};
   logic [47:0] err_lba [8];
   awsc_core u_dut (.*);
   awsc_media_model u_media (.clock_in(clock_in), .sector_request_in(sector_request_out),
      .flush_request_in(flush_request_out), .delay_in(m_dly), .err_idx_in(m_eidx), .err_kind_in(m_kind),
      .sector_done_out(sector_done_in), .sector_err_out(sector_err_in), .flush_done_out(flush_done_in));
   // Clock and hang limit
   always #5 clock_in = ~clock_in;
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         $display("mismatch at %0t: timeout", $time);
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim
   // One command against the reference model of limit, status and addresses
   task automatic run(input logic [7:0] op, fc, fp, input logic [15:0] cnt, eidx, input logic [2:0] kind, input int dly);
      int n;
      int t;
      int lim;
      logic tmo;
      logic [7:0] ee;
      logic [47:0] a;
      logic [47:0] base;
      a = 48'({$random(seed), $random(seed)});
      lim = 100 * (fp != 0 ? int'(fp) : cfg_def[fc[2:0]]) * int'(time_unit_us_in);
      if (lim != 0 && lim < 100 * int'(min_limit_us_in)) lim = 100 * int'(min_limit_us_in);
      base = fc[4] ? err_lba[fc[2:0]] : a;
      taskfile_in = '{fc, fp, cnt, a, 8'hE0, op};
      m_dly = 16'(dly);
      m_eidx = eidx;
      m_kind = kind;
      command_write_in = 1'b1;
      @(negedge clock_in) command_write_in = 1'b0;
      n = 0;
      t = 0;
      while (t < 3000) begin
         #4; // Just before the next rising edge, all outputs settled
         t++;
         if (t == 1) `CHK(command_status_flags_out, 8'h80)
         if (sector_done_in === 1'b1) begin
            `CHK(sector_lba_out, base + 48'(n))
            n++;
         end
         if (complete_out === 1'b1) break;
         @(negedge clock_in);
      end
      tmo = lim != 0 && int'(cnt) * (dly + 1) > lim;
      ee = {7'h00, tmo};
      if (eidx < cnt) ee = ee | {kind[2] && op == awsc_pkg::OP_STREAM_DMA, 2'b00, kind[1], 1'b0, kind[0], 2'b00};
      `CHK(complete_out, 1'b1)
      `CHK(command_error_flags_out, ee)
      `CHK(command_status_flags_out, ee == 8'h00 ? 8'h40 : (fc[6] ? 8'h60 : 8'h41))
      if (!tmo) `CHK(n, int'(cnt))
      if (tmo) `CHK(t >= lim - 3 && t <= lim + 3, 1'b1)
      @(negedge clock_in);
      if (eidx < cnt) begin
         err_lba[fc[2:0]] = base + 48'(eidx);
         hob_in = 1'b0;
         repeat (2) @(negedge clock_in);
         `CHK({lba_high_out, lba_mid_out, lba_low_out}, err_lba[fc[2:0]][23:0])
         hob_in = 1'b1;
         repeat (2) @(negedge clock_in);
         `CHK({lba_high_out, lba_mid_out, lba_low_out}, err_lba[fc[2:0]][47:24])
      end
   endtask : run
   // Reset, stream setup, refused opcode, then the command table
   initial begin
      repeat (4) @(negedge clock_in);
      rst_in = 1'b0;
      cfg_stream_in = 3'h3;
      cfg_default_limit_in = 8'h03;
      cfg_write_in = 1'b1;
      cfg_def[3] = 3;
      @(negedge clock_in) cfg_write_in = 1'b0;
      taskfile_in.opcode = 8'h30;
      command_write_in = 1'b1;
      @(negedge clock_in) command_write_in = 1'b0;
      repeat (3) @(negedge clock_in);
      `CHK(command_status_flags_out, 8'h40)
      `CHK(sector_request_out, 1'b0)
      // Frozen block ignores a stream command
      enable_in = 1'b0;
      taskfile_in.opcode = awsc_pkg::OP_STREAM_PIO;
      command_write_in = 1'b1;
      @(negedge clock_in) command_write_in = 1'b0;
      enable_in = 1'b1;
      repeat (2) @(negedge clock_in);
      `CHK(command_status_flags_out, 8'h40)
      `CHK(sector_request_out, 1'b0)
      run(8'h3B, 8'h42, 8'h00, 16'h0004, 16'h0002, 3'b010, 2);
      run(8'h3A, 8'hC1, 8'h32, 16'h0003, 16'h0001, 3'b100, 1);
      run(8'h3A, 8'h01, 8'h32, 16'h0003, 16'h0002, 3'b001, 1);
      run(8'h3B, 8'h25, 8'h00, 16'h0001, 16'hFFFF, 3'b000, 1);
      run(8'h3B, 8'h52, 8'h00, 16'h0002, 16'hFFFF, 3'b000, 1);
      run(8'h3B, 8'h40, 8'h01, 16'h000A, 16'hFFFF, 3'b000, 50);
      run(8'h3A, 8'h03, 8'h00, 16'h000A, 16'hFFFF, 3'b000, 50);
      run(8'h3B, 8'h06, 8'h00, 16'h000A, 16'hFFFF, 3'b000, 50);
      end_sim();
   end
endmodule : test_ata_write_stream_command
